//--- ssc_pkg.sv
// package: constants and carriers for the spindle speed command interface
package ssc_pkg;

  // register byte offsets on apb
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DELAY  = 8'h04;
  localparam logic [7:0] OFS_CMD0   = 8'h08;
  localparam logic [7:0] OFS_CMD1   = 8'h0C;
  localparam logic [7:0] OFS_MAX    = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_CODE   = 8'h34;

  // control register fields and register reset values
  localparam int CTRL_ARRIVAL_EN = 0;
  localparam int CTRL_NO_OVR     = 1;
  localparam logic [1:0]  CTRL_RST  = 2'h0;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [13:0] SPEED_RST = 14'h0000;

  // signal byte bit positions
  localparam int SRC_SEL_BIT     = 7;
  localparam int GSTOP_BIT       = 6;
  localparam int STOP1_BIT       = 3;
  localparam int STOP2_BIT       = 4;
  localparam int ARRIVAL_BIT     = 4;
  localparam int GEAR1_LO_BIT    = 1;
  localparam int GEAR2_LO_BIT    = 0;
  localparam int SER_CW_BIT      = 5;
  localparam int SER_CCW_BIT     = 4;
  localparam int SER_ORIENT_BIT  = 2;
  localparam int SER_ARRIVED_BIT = 4;
  localparam int SER_DONE_BIT    = 2;

  // speed code full scale and override
  localparam logic [11:0] CODE_FULL = 12'hFFF;
  localparam logic [6:0]  PCT_FULL  = 7'h64;
  localparam int DIV_STEPS = 33;

  // arrival check delay unit
  localparam int CLK_PERIOD_NS = 40;
  localparam int DELAY_UNIT_NS = 1000000;
  localparam int UNIT_CYCLES   = DELAY_UNIT_NS / CLK_PERIOD_NS;

  // control bytes from the plc
  typedef struct packed {
    logic [7:0] g35;
    logic [7:0] g34;
    logic [7:0] g33;
    logic [7:0] g32;
    logic [7:0] g30;
    logic [7:0] g29;
    logic [7:0] g28;
    logic [7:0] g27;
  } ssc_gin_type;

  // status bytes to the plc
  typedef struct packed {
    logic [7:0] f203;
    logic [7:0] f202;
    logic [7:0] f237;
    logic [7:0] f236;
    logic [7:0] f41;
    logic [7:0] f40;
    logic [7:0] f37;
    logic [7:0] f36;
  } ssc_fout_type;

endpackage

//--- ssc_top.sv
// spindle speed command interface: speed selection, override, gating and serial spindles
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ns
module ssc_top #(
  parameter int UNIT_CYCLES = ssc_pkg::UNIT_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire ssc_pkg::ssc_gin_type plc_in,
  input  wire logic [15:0]         first_actual_speed,
  input  wire logic [15:0]         second_actual_speed,
  input  wire logic                speed_cmd_strobe,
  input  wire logic                rapid_to_cut_strobe,
  input  wire logic                thread_or_tap,
  output ssc_pkg::ssc_fout_type    plc_out,
  output logic [11:0]              first_spindle_speed_out,
  output logic [11:0]              second_spindle_speed_out,
  output logic                     feed_enable,
  input  wire logic [2:0][7:0]     serial_ctrl,
  input  wire logic [2:0]          servo_at_speed,
  input  wire logic [2:0]          servo_orient_in_pos,
  output logic [2:0][7:0]          serial_status,
  output logic [2:0]               servo_run_cw,
  output logic [2:0]               servo_run_ccw,
  output logic [2:0]               servo_orient_req
);

  typedef enum logic {SSC_DIV_IDLE, SSC_DIV_RUN} ssc_div_type;

  function automatic logic [6:0] ssc_pct(input logic [3:0] code);
    logic [6:0] p;
    p = 7'h64;
    unique case (code)
      4'h7:    p = 7'h32;
      4'h6:    p = 7'h3C;
      4'h2:    p = 7'h46;
      4'h3:    p = 7'h50;
      4'h1:    p = 7'h5A;
      4'h0:    p = 7'h64;
      4'h4:    p = 7'h6E;
      4'h5:    p = 7'h78;
      default: p = 7'h64;
    endcase
    return p;
  endfunction

  logic [1:0]       ctrl_r;
  logic [15:0]      delay_r;
  logic [1:0][13:0] cmd_r;
  logic [13:0]      max_r [8];
  logic [11:0]      code_r    [2];
  ssc_div_type      div_st_r  [2];
  logic [3:0]       div_cnt_r [2];
  logic [11:0]      div_low_r [2];
  logic [11:0]      div_quo_r [2];
  logic [21:0]      div_rem_r [2];
  logic [20:0]      div_den_r [2];
  logic [32:0]      div_key_r [2];
  logic [15:0]      wait_r;
  logic [31:0]      presc_r;
  wire              wait_idle = wait_r == 16'h0000;
  wire  [1:0]       div_busy;

  // twelve quotient bits, one per clock
  localparam logic [3:0] QUO_LAST = 4'hB;

  // apb decode
  wire        setup_cyc  = psel & ~penable;
  wire        wr_take    = psel & penable & pready & pwrite;
  wire [5:0]  reg_idx    = paddr[7:2];
  wire        hit_ctrl   = paddr == ssc_pkg::OFS_CTRL;
  wire        hit_delay  = paddr == ssc_pkg::OFS_DELAY;
  wire        hit_cmd0   = paddr == ssc_pkg::OFS_CMD0;
  wire        hit_cmd1   = paddr == ssc_pkg::OFS_CMD1;
  wire        hit_max    = paddr >= ssc_pkg::OFS_MAX && paddr < ssc_pkg::OFS_STATUS && paddr[1:0] == 2'b00;
  wire        hit_status = paddr == ssc_pkg::OFS_STATUS;
  wire        hit_code   = paddr == ssc_pkg::OFS_CODE;
  wire        mapped     = hit_ctrl | hit_delay | hit_cmd0 | hit_cmd1 | hit_max | hit_status | hit_code;
  wire [2:0]  max_idx    = 3'(reg_idx - 6'(ssc_pkg::OFS_MAX >> 2));
  wire        arrival_en = ctrl_r[ssc_pkg::CTRL_ARRIVAL_EN];

  wire [31:0] rd_value =
    hit_ctrl   ? {30'h0000_0000, ctrl_r} :
    hit_delay  ? {16'h0000, delay_r} :
    hit_cmd0   ? {18'h0_0000, cmd_r[0]} :
    hit_cmd1   ? {18'h0_0000, cmd_r[1]} :
    hit_max    ? {18'h0_0000, max_r[max_idx]} :
    hit_status ? {28'h000_0000, wait_idle, div_busy[1], div_busy[0], feed_enable} :
    hit_code   ? {4'h0, code_r[1], 4'h0, code_r[0]} :
                 32'h0000_0000;

  // answer in the first access cycle; write lands at that edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= setup_cyc;
      pslverr <= setup_cyc & ~mapped;
      if (setup_cyc) begin
        prdata <= rd_value;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= ssc_pkg::CTRL_RST;
      delay_r <= ssc_pkg::DELAY_RST;
      cmd_r   <= {2{ssc_pkg::SPEED_RST}};
    end else if (ce && wr_take) begin
      if (hit_ctrl) begin
        ctrl_r <= pwdata[1:0];
      end
      if (hit_delay) begin
        delay_r <= pwdata[15:0];
      end
      if (hit_cmd0) begin
        cmd_r[0] <= pwdata[13:0];
      end
      if (hit_cmd1) begin
        cmd_r[1] <= pwdata[13:0];
      end
    end
  end

  // one maximum speed per gear and spindle
  for (genvar m = 0; m < 8; m++) begin : g_max
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        max_r[m] <= ssc_pkg::SPEED_RST;
      end else if (ce && wr_take && hit_max && max_idx == 3'(m)) begin
        max_r[m] <= pwdata[13:0];
      end
    end
  end

  wire [1:0] gear0 = plc_in.g28[ssc_pkg::GEAR1_LO_BIT +: 2];
  wire [1:0] gear1 = plc_in.g29[ssc_pkg::GEAR2_LO_BIT +: 2];
  wire [3:0] ovr0  = plc_in.g30[3:0];
  wire [3:0] ovr1  = plc_in.g30[7:4];
  wire       no_ovr = thread_or_tap | ctrl_r[ssc_pkg::CTRL_NO_OVR];
  wire [6:0] pct0   = no_ovr ? ssc_pkg::PCT_FULL : ssc_pct(ovr0);
  wire [6:0] pct1   = no_ovr ? ssc_pkg::PCT_FULL : ssc_pct(ovr1);

  wire [1:0]       plc_src  = {plc_in.g35[ssc_pkg::SRC_SEL_BIT], plc_in.g33[ssc_pkg::SRC_SEL_BIT]};
  // low byte, then low nibble of the next byte
  wire [1:0][11:0] plc_code = {{plc_in.g35[3:0], plc_in.g34}, {plc_in.g33[3:0], plc_in.g32}};
  // active-low stops, global and per spindle
  wire             gstop_ok = plc_in.g29[ssc_pkg::GSTOP_BIT];
  wire             stop1_ok = plc_in.g27[ssc_pkg::STOP1_BIT];
  wire             stop2_ok = plc_in.g27[ssc_pkg::STOP2_BIT];
  wire [1:0]       run_ok   = {gstop_ok & stop2_ok, gstop_ok & stop1_ok};
  wire [1:0][1:0]  gear_v   = {gear1, gear0};
  wire [1:0][6:0]  pct_v    = {pct1, pct0};
  wire [1:0][11:0] spd_nxt;

  // per spindle: code = cmd * 4095 * pct / (max * 100), clamped to full scale
  for (genvar s = 0; s < 2; s++) begin : g_spd
    // gear stage picks its own maximum
    wire [2:0]  max_pick = {1'(s), gear_v[s]};
    wire [13:0] max_sel  = max_r[max_pick];
    wire [32:0] num      = 33'(cmd_r[s]) * 33'(ssc_pkg::CODE_FULL) * 33'(pct_v[s]);
    wire [20:0] den      = 21'(max_sel) * 21'(ssc_pkg::PCT_FULL);
    wire [32:0] den_top  = {den, 12'h000};
    wire        zero_den = den == 21'h00_0000;
    wire        over     = num >= den_top;
    // restart on any operand change, so a result is never stale for long
    wire        changed  = num != div_key_r[s] || den != div_den_r[s];
    wire [21:0] rem_sh   = {div_rem_r[s][20:0], div_low_r[s][11]};
    wire        fits     = rem_sh >= {1'b0, div_den_r[s]};
    wire [21:0] rem_nxt  = fits ? rem_sh - {1'b0, div_den_r[s]} : rem_sh;
    wire [11:0] quo_nxt  = {div_quo_r[s][10:0], fits};
    wire        last     = div_cnt_r[s] == 4'h0;

    assign div_busy[s] = div_st_r[s] == SSC_DIV_RUN;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        div_st_r[s]  <= SSC_DIV_IDLE;
        div_cnt_r[s] <= 4'h0;
        div_low_r[s] <= 12'h000;
        div_quo_r[s] <= 12'h000;
        div_rem_r[s] <= 22'h00_0000;
        div_den_r[s] <= 21'h00_0000;
        div_key_r[s] <= 33'h0_0000_0000;
        code_r[s]    <= 12'h000;
      end else if (ce) begin
        if (changed) begin
          div_key_r[s] <= num;
          div_den_r[s] <= den;
          div_cnt_r[s] <= QUO_LAST;
          div_low_r[s] <= num[11:0];
          div_quo_r[s] <= 12'h000;
          div_rem_r[s] <= {1'b0, num[32:12]};
          if (zero_den) begin
            // unset maximum: no speed rather than a divide by zero
            div_st_r[s] <= SSC_DIV_IDLE;
            code_r[s]   <= 12'h000;
          end else if (over) begin
            div_st_r[s] <= SSC_DIV_IDLE;
            code_r[s]   <= ssc_pkg::CODE_FULL;
          end else begin
            div_st_r[s] <= SSC_DIV_RUN;
          end
        end else if (div_busy[s]) begin
          div_rem_r[s] <= rem_nxt;
          div_low_r[s] <= {div_low_r[s][10:0], 1'b0};
          div_quo_r[s] <= quo_nxt;
          if (last) begin
            div_st_r[s] <= SSC_DIV_IDLE;
            code_r[s]   <= quo_nxt;
          end else begin
            div_cnt_r[s] <= div_cnt_r[s] - 4'h1;
          end
        end
      end
    end

    // plc code bypasses override and gear maximum
    assign spd_nxt[s] = !run_ok[s] ? 12'h000 : plc_src[s] ? plc_code[s] : code_r[s];
  end

  // status bytes and speed outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_spindle_speed_out  <= 12'h000;
      second_spindle_speed_out <= 12'h000;
      plc_out                  <= '0;
    end else if (ce) begin
      first_spindle_speed_out  <= spd_nxt[0];
      second_spindle_speed_out <= spd_nxt[1];
      plc_out.f36              <= code_r[0][7:0];
      plc_out.f37              <= {4'h0, code_r[0][11:8]};
      plc_out.f236             <= code_r[1][7:0];
      plc_out.f237             <= {4'h0, code_r[1][11:8]};
      plc_out.f40              <= first_actual_speed[7:0];
      plc_out.f41              <= first_actual_speed[15:8];
      plc_out.f202             <= second_actual_speed[7:0];
      plc_out.f203             <= second_actual_speed[15:8];
    end
  end

  // programmed delay before the arrival input is trusted
  wire        arrival_in = plc_in.g29[ssc_pkg::ARRIVAL_BIT];
  wire        wait_start = speed_cmd_strobe | rapid_to_cut_strobe;
  wire        unit_tick  = presc_r == 32'h0000_0000;
  wire [31:0] unit_last  = 32'(UNIT_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r  <= ssc_pkg::DELAY_RST;
      presc_r <= 32'h0000_0000;
    end else if (ce) begin
      if (wait_start) begin
        wait_r  <= delay_r;
        presc_r <= unit_last;
      end else if (!wait_idle) begin
        if (unit_tick) begin
          wait_r  <= wait_r - 16'h0001;
          presc_r <= unit_last;
        end else begin
          presc_r <= presc_r - 32'h0000_0001;
        end
      end
    end
  end

  // feed gated only while the arrival check is enabled
  // a fresh strobe blocks feed at once, the old arrival level is stale
  wire feed_nxt = ~arrival_en | (wait_idle & arrival_in & ~wait_start);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feed_enable <= 1'b0;
    end else if (ce) begin
      feed_enable <= feed_nxt;
    end
  end

  // three serial spindles, each with its own control and status byte
  for (genvar k = 0; k < 3; k++) begin : g_ser
    wire       cw_req  = serial_ctrl[k][ssc_pkg::SER_CW_BIT];
    wire       ccw_req = serial_ctrl[k][ssc_pkg::SER_CCW_BIT];
    wire       orient  = serial_ctrl[k][ssc_pkg::SER_ORIENT_BIT];
    wire [7:0] arr_bit = 8'(servo_at_speed[k]) << ssc_pkg::SER_ARRIVED_BIT;
    // done only while orientation is still requested
    wire [7:0] done_bt = 8'(orient & servo_orient_in_pos[k]) << ssc_pkg::SER_DONE_BIT;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        servo_run_cw[k]     <= 1'b0;
        servo_run_ccw[k]    <= 1'b0;
        servo_orient_req[k] <= 1'b0;
        serial_status[k]    <= 8'h00;
      end else if (ce) begin
        // both directions at once is refused: spindle stays stopped
        servo_run_cw[k]     <= cw_req & ~ccw_req;
        servo_run_ccw[k]    <= ccw_req & ~cw_req;
        // orientation request passes straight to the servo
        servo_orient_req[k] <= orient;
        serial_status[k]    <= arr_bit | done_bt;
      end
    end
  end
endmodule

//--- ssc_checker.sv
// checker: port-level properties of the spindle speed command interface
`timescale 1ns/1ns
module ssc_checker (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire ssc_pkg::ssc_gin_type  plc_in,
  input wire logic [15:0]           first_actual_speed,
  input wire ssc_pkg::ssc_fout_type plc_out,
  input wire logic [11:0]           first_spindle_speed_out,
  input wire logic [11:0]           second_spindle_speed_out,
  input wire logic [2:0][7:0]       serial_ctrl,
  input wire logic [2:0]            servo_at_speed,
  input wire logic [2:0][7:0]       serial_status,
  input wire logic [2:0]            servo_run_cw,
  input wire logic [2:0]            servo_run_ccw,
  input wire logic [2:0]            servo_orient_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // inputs held four cycles give the output time to settle
  property p_plc1; (plc_in.g33[7] && plc_in.g29[6] && plc_in.g27[3] && $stable(plc_in))[*4]
    |-> first_spindle_speed_out == {plc_in.g33[3:0], plc_in.g32}; endproperty
  a_plc1: assert property (p_plc1) else $error("first plc code not passed");
  property p_plc2; (plc_in.g35[7] && plc_in.g29[6] && plc_in.g27[4] && $stable(plc_in))[*4]
    |-> second_spindle_speed_out == {plc_in.g35[3:0], plc_in.g34}; endproperty
  a_plc2: assert property (p_plc2) else $error("second plc code not passed");
  property p_gstop; (!plc_in.g29[6])[*4] |-> first_spindle_speed_out == 0 && second_spindle_speed_out == 0; endproperty
  a_gstop: assert property (p_gstop) else $error("stop did not zero speed");
  property p_act1; $stable(first_actual_speed)[*4] |-> {plc_out.f41, plc_out.f40} == first_actual_speed; endproperty
  a_act1: assert property (p_act1) else $error("actual speed not reported");
  property p_cw; (serial_ctrl[0][5] && !serial_ctrl[0][4])[*4] |-> servo_run_cw[0] && !servo_run_ccw[0]; endproperty
  a_cw: assert property (p_cw) else $error("clockwise run missing");
  property p_inval; (serial_ctrl[1][5] && serial_ctrl[1][4])[*4] |-> !servo_run_cw[1] && !servo_run_ccw[1]; endproperty
  a_inval: assert property (p_inval) else $error("both directions ran");
  property p_arr; servo_at_speed[1][*4] |-> serial_status[1][4]; endproperty
  a_arr: assert property (p_arr) else $error("arrived status missing");
  property p_orq; serial_ctrl[2][2][*4] |-> servo_orient_req[2]; endproperty
  a_orq: assert property (p_orq) else $error("orientation not requested");
endmodule

bind ssc_top ssc_checker chk_i (.*);

//--- ssc_plc_model.sv
// plc partner: assembles the control bytes handed to the interface
`timescale 1ns/1ns
module ssc_plc_model (
  input wire logic [1:0]       src_sel,
  input wire logic [1:0][11:0] code,
  input wire logic [2:0]       stop_n,
  input wire logic [7:0]       ovr,
  input wire logic [3:0]       gear,
  input wire logic             arr_req,
  input wire logic [15:0]      actual,
  input wire logic [15:0]      target,
  output ssc_pkg::ssc_gin_type plc_in
);
  // arrival only once measured speed reaches target
  wire logic arrived = arr_req && actual >= target;
  // byte layout of the control bytes
  assign plc_in = '{g35: {src_sel[1], 3'h0, code[1][11:8]}, g34: code[1][7:0], g33: {src_sel[0], 3'h0, code[0][11:8]},
    g32: code[0][7:0], g30: ovr, g29: {1'b0, stop_n[0], 1'b0, arrived, 2'h0, gear[3:2]},
    g28: {5'h00, gear[1:0], 1'b0}, g27: {3'h0, stop_n[2:1], 3'h0}};
endmodule

//--- testbench.sv
// testbench: drives the interface and compares it with an integer model
`timescale 1ns/1ns
module testbench;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic speed_cmd_strobe = 0, rapid_to_cut_strobe = 0, thread_or_tap = 0, arr_req = 0;
  logic [7:0] paddr = '0, ovr = '0;
  logic [31:0] pwdata = '0, q;
  logic [1:0] src = '0;
  logic [1:0][11:0] code = '0;
  logic [2:0] stop_n = 3'h7, servo_at_speed = 3'h7, servo_orient_in_pos = 3'h7;
  logic [3:0] gear = '0;
  logic [15:0] first_actual_speed = '0, tgt = 16'h0064;
  logic [2:0][7:0] serial_ctrl = '0;
  wire logic pready, pslverr, feed_enable;
  wire logic [31:0] prdata;
  wire logic [11:0] first_spindle_speed_out, second_spindle_speed_out;
  wire logic [2:0][7:0] serial_status;
  wire logic [2:0] servo_run_cw, servo_run_ccw, servo_orient_req;
  wire logic [15:0] second_actual_speed = ~first_actual_speed;
  wire ssc_pkg::ssc_gin_type plc_in;
  wire ssc_pkg::ssc_fout_type plc_out;
  int n_fail = 0, n_checks = 0, cyc = 0;
  int ov[8] = '{7, 6, 2, 3, 1, 0, 4, 5};
  logic [7:0] sc[4] = '{8'h20, 8'h10, 8'h30, 8'h04};
  logic [4:0] se[4] = '{5'h11, 5'h09, 5'h01, 5'h07};
  always #20 pclk = ~pclk;
  ssc_plc_model plc (.src_sel(src), .code(code), .stop_n(stop_n), .ovr(ovr), .gear(gear), .arr_req(arr_req),
    .actual(first_actual_speed), .target(tgt), .plc_in(plc_in));
  ssc_top #(.UNIT_CYCLES(4)) dut (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    q = $urandom(32'h87bd);
    wt(2);
    presetn <= 1'b1;
    wt(1);
    src <= 2'h3;
    for (int i = 0; i < 4; i++) begin
      code <= {12'($urandom), 12'($urandom)};
      ovr <= 8'($urandom);
      wt(8);
      chk({first_spindle_speed_out, second_spindle_speed_out}, {code[0], code[1]});
    end
    stop_n <= 3'h6;
    wt(8);
    chk({first_spindle_speed_out, second_spindle_speed_out}, 0);
    stop_n <= 3'h5;
    wt(8);
    chk({first_spindle_speed_out, second_spindle_speed_out}, {12'h000, code[1]});
    stop_n <= 3'h7;
    src <= 2'h0;
    apb(1'b0, ssc_pkg::OFS_CTRL, 0);
    chk(q, 32'(ssc_pkg::CTRL_RST));
    apb(1'b0, 8'hfc, 0);
    apb(1'b1, ssc_pkg::OFS_CMD0, 32'h0000_07d0);
    apb(1'b1, ssc_pkg::OFS_CMD1, 32'h0000_07d0);
    for (int g = 0; g < 8; g++) apb(1'b1, ssc_pkg::OFS_MAX + 8'(4 * g), g == 2 ? 32'h0000_07d0 : 32'h0000_0fff);
    speed_cmd_strobe <= 1'b1;
    wt(1);
    speed_cmd_strobe <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      ovr <= {4'(ov[7 - i]), 4'(ov[i])};
      wt(40);
      chk({first_spindle_speed_out, second_spindle_speed_out}, {12'(20 * (50 + 10 * i)), 12'(20 * (120 - 10 * i))});
      if (i == 5) chk({plc_out.f37[3:0], plc_out.f36}, 2000);
      if (i == 5) chk({plc_out.f237[3:0], plc_out.f236}, 1400);
    end
    thread_or_tap <= 1'b1;
    wt(40);
    chk(first_spindle_speed_out, 2000);
    thread_or_tap <= 1'b0;
    gear <= 4'h2;
    wt(40);
    chk(first_spindle_speed_out, 4095);
    apb(1'b1, ssc_pkg::OFS_DELAY, 3);
    apb(1'b1, ssc_pkg::OFS_CTRL, 1);
    arr_req <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      speed_cmd_strobe <= k < 2;
      rapid_to_cut_strobe <= k == 2;
      wt(1);
      speed_cmd_strobe <= 1'b0;
      rapid_to_cut_strobe <= 1'b0;
      wt(2);
      chk(feed_enable, 0);
      first_actual_speed <= 16'h0064;
      wt(18);
      chk({feed_enable, plc_out.f41, plc_out.f40}, 32'h0001_0064);
      chk({plc_out.f203, plc_out.f202}, 32'h0000_ff9b);
    end
    apb(1'b1, ssc_pkg::OFS_CTRL, 0);
    first_actual_speed <= 16'h0000;
    wt(4);
    chk(feed_enable, 1);
    for (int s = 0; s < 3; s++)
      for (int k = 0; k < 4; k++) begin
        serial_ctrl[s] <= sc[k];
        wt(6);
        chk({servo_run_cw[s], servo_run_ccw[s], servo_orient_req[s], serial_status[s][2], serial_status[s][4]}, se[k]);
      end
    tally_and_finish;
  end
endmodule
